/* File: verilog/esc_rx_sa_bank.sv */
// Receive Sa capture, remote alarm capture and receive master mode register bank.
`timescale 1ns/100ps
module esc_rx_sa_bank
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic [9:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_nfas_valid,
   input wire logic [3:0] i_nfas_frame,
   input wire logic i_nfas_alarm,
   input wire logic [4:0] i_nfas_national,
   output logic [7:0] o_rdata,
   output logic o_irq,
   output logic o_framer_run,
   output logic o_rx_sync_off,
   output logic o_rx_soft_clear,
   output logic o_rx_standard_e1,
   output logic o_resync_pulse
);

   // ==========================================
   // State

   typedef enum logic [2:0]
   {
      ESC_IDLE = 3'b001,
      ESC_RUN = 3'b010,
      ESC_LOWPWR = 3'b100
   } esc_mode_t;

   typedef struct packed {
      esc_mode_t mode;
      logic [7:0] alarm_acc;
      logic [4:0][7:0] nat_acc;
      logic [7:0] alarm;
      logic [4:0][7:0] nat;
      logic [4:0] last_nat;
      logic [7:0] master;
      logic [7:0] ctl_t1;
      logic [7:0] ctl_e1;
      logic [1:0] irq_status;
      logic [1:0] irq_mask;
      logic [4:0] nat_mask;
      logic resync_prev;
      logic [7:0] rdata;
      logic irq;
      logic resync;
   } esc_state_t;

   esc_state_t s_q;
   esc_state_t s_d;
   esc_pkg::esc_nfas_t nfas;
   esc_pkg::esc_bus_t bus;
   logic [3:0] code;
   logic rx_active;
   logic code_clear;

   // Odd frame n maps to bit (n-1)/2, so frame 15 lands on bit 7.
   function automatic logic [2:0] frame_slot(input logic [3:0] frame);
      frame_slot = frame[3:1];
   endfunction

   // Offsets are local to one port; the port base, index times stride, is removed upstream.
   function automatic logic is_addr(input logic [9:0] a, input logic [9:0] reg_off);
      is_addr = (a == reg_off);
   endfunction

   assign nfas = '{valid: i_nfas_valid, frame: i_nfas_frame,
                   remote_alarm: i_nfas_alarm, national: i_nfas_national};
   assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

   // Capture only runs in E1 mode with the framer started and the receiver out of reset.
   assign rx_active = (s_q.mode == ESC_RUN) && s_q.master[esc_pkg::MM_STANDARD]
                      && !s_q.master[esc_pkg::MM_SOFT_CLEAR];
   assign code_clear = !rx_active;

   esc_nat6_code u_code
   (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_clear(code_clear),
      .i_shift(rx_active && nfas.valid && nfas.frame[0]),
      .i_bit(nfas.national[2]),
      .o_code(code)
   );

   // ==========================================
   // Next state

   always_comb
   begin
      logic [1:0] ev;
      logic [2:0] slot;
      ev = 2'h0;
      slot = frame_slot(nfas.frame);
      s_d = s_q;
      s_d.resync = 1'b0;
      s_d.rdata = esc_pkg::RESET_BYTE;

      // Mode sequencing on init done.
      unique case (s_q.mode)
         ESC_IDLE:
         begin
            if (s_q.master[esc_pkg::MM_INIT_DONE])
            begin
               s_d.mode = s_q.master[esc_pkg::MM_FRAMER_ON] ? ESC_RUN : ESC_LOWPWR;
            end
         end
         ESC_RUN:
         begin
            if (!s_q.master[esc_pkg::MM_INIT_DONE])
            begin
               s_d.mode = ESC_IDLE;
            end
            else if (!s_q.master[esc_pkg::MM_FRAMER_ON])
            begin
               s_d.mode = ESC_LOWPWR;
            end
         end
         ESC_LOWPWR:
         begin
            if (!s_q.master[esc_pkg::MM_INIT_DONE])
            begin
               s_d.mode = ESC_IDLE;
            end
            else if (s_q.master[esc_pkg::MM_FRAMER_ON])
            begin
               s_d.mode = ESC_RUN;
            end
         end
      endcase

      // Frame capture from odd (non-align) frames.
      if (s_q.master[esc_pkg::MM_SOFT_CLEAR])
      begin
         s_d.alarm_acc = esc_pkg::RESET_BYTE;
         s_d.nat_acc = '0;
      end
      else if (rx_active && nfas.valid && nfas.frame[0])
      begin
         s_d.alarm_acc[slot] = nfas.remote_alarm;
         for (int i = 0; i < 5; i++)
         begin
            s_d.nat_acc[4 - i][slot] = nfas.national[4 - i];
         end
         s_d.last_nat = nfas.national;
         if (|((nfas.national ^ s_q.last_nat) & s_q.nat_mask))
         begin
            ev[esc_pkg::IRQ_NAT_CHANGE] = 1'b1;
         end
         if (nfas.frame == esc_pkg::FRAMES_PER_MF)
         begin
            // Publish the whole multiframe at once so reads never mix two.
            s_d.alarm = s_d.alarm_acc;
            s_d.nat = s_d.nat_acc;
            ev[esc_pkg::IRQ_MF_DONE] = 1'b1;
         end
      end

      // Register writes; capture registers ignore them.
      if (bus.wr)
      begin
         if (is_addr(bus.addr, esc_pkg::REG_MASTER_MODE))
         begin
            s_d.master = bus.wdata & esc_pkg::MM_WRITABLE;
         end
         if (is_addr(bus.addr, esc_pkg::REG_CONTROL_ONE))
         begin
            if (s_q.master[esc_pkg::MM_STANDARD])
            begin
               s_d.ctl_e1 = bus.wdata & esc_pkg::RC_E1_WRITABLE;
            end
            else
            begin
               s_d.ctl_t1 = bus.wdata;
            end
         end
         if (is_addr(bus.addr, esc_pkg::REG_IRQ_STATUS))
         begin
            s_d.irq_status = s_q.irq_status & ~bus.wdata[1:0];
         end
         if (is_addr(bus.addr, esc_pkg::REG_IRQ_MASK))
         begin
            s_d.irq_mask = bus.wdata[1:0];
         end
         if (is_addr(bus.addr, esc_pkg::REG_NAT_CHANGE_MASK))
         begin
            s_d.nat_mask = bus.wdata[4:0];
         end
      end
      // Set wins over a simultaneous write-one clear.
      s_d.irq_status = s_d.irq_status | ev;

      // Resync pulse on rising edge of the bit in the active layout.
      s_d.resync_prev = s_d.master[esc_pkg::MM_STANDARD] ? s_d.ctl_e1[esc_pkg::RC_RESYNC]
                                                         : s_d.ctl_t1[esc_pkg::RC_RESYNC];
      // A layout switch alone is not a toggle of the bit, so it must not start a resync.
      s_d.resync = s_d.resync_prev && !s_q.resync_prev
                   && (s_d.master[esc_pkg::MM_STANDARD]
                       == s_q.master[esc_pkg::MM_STANDARD]);

      if (bus.rd)
      begin
         unique case (1'b1)
            is_addr(bus.addr, esc_pkg::REG_REMOTE_ALARM): s_d.rdata = s_q.alarm;
            is_addr(bus.addr, esc_pkg::REG_NAT4): s_d.rdata = s_q.nat[4];
            is_addr(bus.addr, esc_pkg::REG_NAT5): s_d.rdata = s_q.nat[3];
            is_addr(bus.addr, esc_pkg::REG_NAT6): s_d.rdata = s_q.nat[2];
            is_addr(bus.addr, esc_pkg::REG_NAT7): s_d.rdata = s_q.nat[1];
            is_addr(bus.addr, esc_pkg::REG_NAT8): s_d.rdata = s_q.nat[0];
            is_addr(bus.addr, esc_pkg::REG_LAST_NAT): s_d.rdata = {3'h0, s_q.last_nat};
            is_addr(bus.addr, esc_pkg::REG_NAT6_CODE): s_d.rdata = {4'h0, code};
            is_addr(bus.addr, esc_pkg::REG_MASTER_MODE): s_d.rdata = s_q.master;
            is_addr(bus.addr, esc_pkg::REG_CONTROL_ONE):
               s_d.rdata = s_q.master[esc_pkg::MM_STANDARD] ? s_q.ctl_e1 : s_q.ctl_t1;
            is_addr(bus.addr, esc_pkg::REG_IRQ_STATUS): s_d.rdata = {6'h0, s_q.irq_status};
            is_addr(bus.addr, esc_pkg::REG_IRQ_MASK): s_d.rdata = {6'h0, s_q.irq_mask};
            is_addr(bus.addr, esc_pkg::REG_NAT_CHANGE_MASK): s_d.rdata = {3'h0, s_q.nat_mask};
            default: s_d.rdata = esc_pkg::RESET_BYTE;
         endcase
      end

      s_d.irq = |(s_d.irq_status & s_d.irq_mask);
   end

   // ==========================================
   // Registers

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         s_q <= '0;
         s_q.mode <= ESC_IDLE;
      end
      else if (i_ce)
      begin
         s_q <= s_d;
      end
   end

   assign o_rdata = s_q.rdata;
   assign o_irq = s_q.irq;
   // The state is one-hot, so the run bit itself drives the pin without a decoder.
   assign o_framer_run = s_q.mode[1];
   assign o_rx_sync_off = s_q.master[esc_pkg::MM_SYNC_OFF];
   assign o_rx_soft_clear = s_q.master[esc_pkg::MM_SOFT_CLEAR];
   assign o_rx_standard_e1 = s_q.master[esc_pkg::MM_STANDARD];
   assign o_resync_pulse = s_q.resync;

   // ==========================================
   // Checks

   sequence seq_mf_end;
      i_ce && rx_active && i_nfas_valid && i_nfas_frame == esc_pkg::FRAMES_PER_MF
         && !o_rx_soft_clear;
   endsequence

   sequence seq_e1_resync_rise;
      i_ce && i_wr && i_addr == esc_pkg::REG_CONTROL_ONE && o_rx_standard_e1
         && i_wdata[esc_pkg::RC_RESYNC] && !s_q.ctl_e1[esc_pkg::RC_RESYNC];
   endsequence

   AST_MF_PUBLISH: assert property (@(posedge i_clk) disable iff (i_rst)
      seq_mf_end |=> (s_q.alarm[7] == $past(i_nfas_alarm)))
      else $error("Remote alarm frame 15 not published at multiframe end.");

   AST_SA4_F15: assert property (@(posedge i_clk) disable iff (i_rst)
      seq_mf_end |=> (s_q.nat[4][7] == $past(i_nfas_national[4])))
      else $error("Sa4 frame 15 bit wrong.");

   AST_LAST_NAT: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && i_rd && i_addr == esc_pkg::REG_LAST_NAT) |=> (o_rdata[7:5] == 3'h0))
      else $error("Last Sa register upper bits not zero.");

   AST_IRQ_LEVEL: assert property (@(posedge i_clk) disable iff (i_rst)
      o_irq == |(s_q.irq_status & s_q.irq_mask))
      else $error("Interrupt output disagrees with status and mask.");

   AST_LOWPWR: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && s_q.mode == ESC_RUN && !s_q.master[esc_pkg::MM_FRAMER_ON]) |=> !o_framer_run)
      else $error("Framer not stopped when disabled.");

   AST_INIT_START: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && s_q.mode == ESC_IDLE && s_q.master[esc_pkg::MM_INIT_DONE]
         && s_q.master[esc_pkg::MM_FRAMER_ON]) |=> o_framer_run)
      else $error("Framer did not start after init done.");

   AST_SOFT_HOLD: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && o_rx_soft_clear)
      |=> ($stable(s_q.last_nat) && $stable(s_q.alarm) && $stable(code)))
      else $error("Receiver active or register cleared during soft reset.");

   AST_RESYNC_ONCE: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && o_resync_pulse) |=> !o_resync_pulse)
      else $error("Resync pulse longer than one cycle.");

   AST_RO_CAPTURE: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && i_wr && i_addr == esc_pkg::REG_REMOTE_ALARM && !(rx_active && i_nfas_valid))
      |=> $stable(s_q.alarm))
      else $error("Capture register changed by a write.");

   AST_MF_FLAG: assert property (@(posedge i_clk) disable iff (i_rst)
      seq_mf_end |=> s_q.irq_status[esc_pkg::IRQ_MF_DONE])
      else $error("Multiframe done flag not set at multiframe end.");

   AST_EVEN_SKIP: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && i_nfas_valid && !i_nfas_frame[0]) |=> $stable(s_q.last_nat))
      else $error("Even frame changed the last Sa bits.");

   AST_T1_SKIP: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && !o_rx_standard_e1) |=> ($stable(s_q.alarm) && $stable(s_q.last_nat)))
      else $error("Capture changed in T1 mode.");

   AST_E1_CTL_TOP: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && i_rd && i_addr == esc_pkg::REG_CONTROL_ONE && o_rx_standard_e1)
      |=> !o_rdata[7])
      else $error("Control one bit 7 not zero in E1 layout.");

   AST_RESYNC_RISE: assert property (@(posedge i_clk) disable iff (i_rst)
      seq_e1_resync_rise |=> o_resync_pulse)
      else $error("Resync bit rise did not start a resync.");

endmodule

/* File: common/esc_pkg.sv */
// Package with register map, field positions and carrier types for the Sa capture bank.
package esc_pkg;

   // ==========================================
   // Register offsets, index within one port
   localparam logic [9:0] REG_REMOTE_ALARM = 10'h068;
   localparam logic [9:0] REG_NAT4 = 10'h069;
   localparam logic [9:0] REG_NAT5 = 10'h06a;
   localparam logic [9:0] REG_NAT6 = 10'h06b;
   localparam logic [9:0] REG_NAT7 = 10'h06c;
   localparam logic [9:0] REG_NAT8 = 10'h06d;
   localparam logic [9:0] REG_LAST_NAT = 10'h06e;
   localparam logic [9:0] REG_NAT6_CODE = 10'h06f;
   localparam logic [9:0] REG_MASTER_MODE = 10'h080;
   localparam logic [9:0] REG_CONTROL_ONE = 10'h081;
   localparam logic [9:0] REG_IRQ_STATUS = 10'h0f0;
   localparam logic [9:0] REG_IRQ_MASK = 10'h0f1;
   localparam logic [9:0] REG_NAT_CHANGE_MASK = 10'h0f2;
   localparam logic [11:0] PORT_STRIDE = 12'h200;
   localparam logic [1:0] PORT_INDEX = 2'h0;

   // ==========================================
   // Field positions
   localparam int MM_FRAMER_ON = 7;
   localparam int MM_INIT_DONE = 6;
   localparam int MM_SYNC_OFF = 5;
   localparam int MM_SOFT_CLEAR = 1;
   localparam int MM_STANDARD = 0;
   localparam int RC_RESYNC = 0;
   localparam int IRQ_NAT_CHANGE = 0;
   localparam int IRQ_MF_DONE = 1;
   localparam logic [7:0] MM_WRITABLE = 8'he3;
   localparam logic [7:0] RC_E1_WRITABLE = 8'h7f;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [3:0] FRAMES_PER_MF = 4'hf;

   // ==========================================
   // Carrier types
   typedef struct packed {
      logic valid;
      logic [3:0] frame;
      logic remote_alarm;
      logic [4:0] national;
   } esc_nfas_t;

   typedef struct packed {
      logic [9:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } esc_bus_t;

endpackage

/* File: verilog/esc_nat6_code.sv */
// Sa6 codeword collector: a four-bit codeword latched after every fourth Sa6 bit.
`timescale 1ns/100ps
module esc_nat6_code
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_clear,
   input wire logic i_shift,
   input wire logic i_bit,
   output logic [3:0] o_code
);

   typedef struct packed {
      logic [3:0] shift;
      logic [1:0] cnt;
      logic [3:0] code;
   } esc_code_state_t;

   esc_code_state_t s_q;
   esc_code_state_t s_d;

   // Not aligned to the submultiframe, so any rotation of a codeword shows up.
   always_comb
   begin
      s_d = s_q;
      if (i_clear)
      begin
         // The reported codeword is a register and must survive a soft reset or a
         // mode change; only the collection window restarts.
         s_d.shift = 4'h0;
         s_d.cnt = 2'h0;
      end
      else if (i_shift)
      begin
         s_d.shift = {s_q.shift[2:0], i_bit};
         s_d.cnt = s_q.cnt + 2'h1;
         if (s_q.cnt == 2'h3)
         begin
            s_d.code = {s_q.shift[2:0], i_bit};
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         s_q <= '0;
      end
      else if (i_ce)
      begin
         s_q <= s_d;
      end
   end

   assign o_code = s_q.code;

   AST_CODE_FOUR: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && !i_clear && i_shift && s_q.cnt == 2'h3)
      |=> (o_code == {$past(s_q.shift[2:0]), $past(i_bit)}))
      else $error("Sa6 code not updated after four bits.");

endmodule

/* File: verif/esc_line_model.sv */
// Behavioural far-end line terminal that sends E1 multiframes into the receive bank.
`timescale 1ns/100ps
module esc_line_model
(
   input wire logic i_clk,
   output logic o_valid,
   output logic [3:0] o_frame,
   output logic o_alarm,
   output logic [4:0] o_national
);
   initial
   begin
      o_valid = 1'b0;
      o_frame = 4'h0;
      o_alarm = 1'b0;
      o_national = 5'h00;
   end

   // =========================================
   // Multiframe sender
   // Even frames carry the inverse of the odd-frame bits, so a frame filter that lets
   // them through corrupts the captures. Between frames the lines show the inverse of
   // the last value, since nothing qualifies them there.
   task automatic send_mf(input logic [7:0] ra, input logic [39:0] sa, input int gap);
      int k;
      for (int f = 0; f < 16; f++)
      begin
         k = f / 2;
         @(posedge i_clk);
         o_valid <= 1'b1;
         o_frame <= 4'(f);
         if (f % 2 == 1)
         begin
            o_alarm <= ra[k];
            o_national <= {sa[32+k], sa[24+k], sa[16+k], sa[8+k], sa[k]};
         end
         else
         begin
            o_alarm <= ~ra[k];
            o_national <= ~{sa[32+k], sa[24+k], sa[16+k], sa[8+k], sa[k]};
         end
         @(posedge i_clk);
         o_valid <= 1'b0;
         o_alarm <= ~o_alarm;
         o_national <= ~o_national;
         repeat (gap) @(posedge i_clk);
      end
   endtask
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the receive Sa capture and master mode register bank.
`timescale 1ns/100ps
module tb;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [9:0] addr = 10'h000;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic n_valid, n_alarm;
   logic [3:0] n_frame;
   logic [4:0] n_nat;
   logic [7:0] o_rdata;
   logic o_irq, o_framer_run, o_rx_sync_off, o_rx_soft_clear, o_rx_standard_e1;
   logic o_resync_pulse;
   logic [7:0] cap [8] = '{default: 8'h00};
   logic [3:0] codes [5] = '{4'h8, 4'ha, 4'hc, 4'he, 4'hf};
   logic [9:0] ctl [5] = '{10'h080, 10'h081, 10'h0f0, 10'h0f1, 10'h0f2};
   int bad_count = 0;
   int total_checks = 0;
   int pulses = 0;
   int pulse_base = 0;

   // =========================================
   // Clock, partner and design
   initial
   begin
      forever #50 i_clk = ~i_clk;
   end

   esc_line_model u_line (.i_clk(i_clk), .o_valid(n_valid), .o_frame(n_frame),
      .o_alarm(n_alarm), .o_national(n_nat));

   esc_rx_sa_bank u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_nfas_valid(n_valid),
      .i_nfas_frame(n_frame), .i_nfas_alarm(n_alarm), .i_nfas_national(n_nat),
      .o_rdata(o_rdata), .o_irq(o_irq), .o_framer_run(o_framer_run),
      .o_rx_sync_off(o_rx_sync_off), .o_rx_soft_clear(o_rx_soft_clear),
      .o_rx_standard_e1(o_rx_standard_e1), .o_resync_pulse(o_resync_pulse));

   always @(posedge i_clk)
   begin
      if (o_resync_pulse === 1'b1)
      begin
         pulses <= pulses + 1;
      end
   end

   // =========================================
   // Bus tasks and comparison
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrt(input logic [9:0] a, input logic [7:0] d);
      @(posedge i_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge i_clk);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the read edge, so sample just after it.
   task automatic rdc(input logic [9:0] a, input logic [7:0] exp);
      @(posedge i_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge i_clk);
      rd <= 1'b0;
      #1;
      chk(o_rdata, exp);
   endtask

   function automatic logic [3:0] rev(input logic [3:0] p);
      return {p[0], p[1], p[2], p[3]};
   endfunction

   // Sends one multiframe; the six capture bytes, last bits and code change only if upd.
   task automatic mf(input logic [7:0] ra, input logic [3:0] p, input logic [7:0] s,
      input logic upd, input int gap);
      logic [39:0] sa;
      sa = {s, s ^ 8'h5a, rev(p), rev(p), ~s, s ^ 8'h0f};
      u_line.send_mf(ra, sa, gap);
      if (upd)
      begin
         cap = '{ra, sa[39:32], sa[31:24], sa[23:16], sa[15:8], sa[7:0],
            {3'h0, sa[39], sa[31], sa[23], sa[15], sa[7]}, {4'h0, p}};
      end
      for (int i = 0; i < 8; i++)
      begin
         rdc(10'h068 + 10'(i), cap[i]);
      end
   endtask

   task automatic test_done();
      if (bad_count == 0 && total_checks > 0)
      begin
         $display("NO MISMATCHES");
      end
      else
      begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial
   begin
      #3_000_000;
      bad_count++;
      test_done();
   end

   // =========================================
   // Tests
   initial
   begin
      repeat (5) @(posedge i_clk);
      i_rst <= 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         rdc(10'h068 + 10'(i), 8'h00);
      end
      foreach (ctl[i]) rdc(ctl[i], 8'h00);
      wrt(10'h068, 8'hff);
      rdc(10'h068, 8'h00);
      rdc(10'h070, 8'h00);
      wrt(10'h081, 8'hfe);
      rdc(10'h081, 8'hfe);
      wrt(10'h080, 8'ha1);
      rdc(10'h081, 8'h00);
      wrt(10'h081, 8'hfe);
      rdc(10'h081, 8'h7e);
      chk({6'h00, o_rx_sync_off, o_rx_standard_e1}, 8'h03);
      chk({7'h00, o_framer_run}, 8'h00);
      wrt(10'h0f2, 8'h1f);
      wrt(10'h0f1, 8'h01);
      wrt(10'h080, 8'he1);
      repeat (3) @(posedge i_clk);
      chk({7'h00, o_framer_run}, 8'h01);
      for (int i = 0; i < 5; i++)
      begin
         mf(8'ha5 ^ 8'(i * 37), codes[i], 8'h3c + 8'(i), 1'b1, (i % 2) * 3);
      end
      rdc(10'h0f0, 8'h03);
      chk({7'h00, o_irq}, 8'h01);
      wrt(10'h0f1, 8'h00);
      repeat (2) @(posedge i_clk);
      chk({7'h00, o_irq}, 8'h00);
      wrt(10'h0f1, 8'h02);
      repeat (2) @(posedge i_clk);
      chk({7'h00, o_irq}, 8'h01);
      wrt(10'h0f0, 8'h03);
      repeat (2) @(posedge i_clk);
      chk({7'h00, o_irq}, 8'h00);
      rdc(10'h0f0, 8'h00);
      wrt(10'h0f2, 8'h00);
      mf(8'h3c, 4'h5, 8'h96, 1'b1, 0);
      rdc(10'h0f0, 8'h02);
      wrt(10'h080, 8'he3);
      repeat (2) @(posedge i_clk);
      chk({7'h00, o_rx_soft_clear}, 8'h01);
      mf(8'hff, 4'h3, 8'h00, 1'b0, 0);
      rdc(10'h080, 8'he3);
      wrt(10'h080, 8'he1);
      repeat (2) @(posedge i_clk);
      chk({7'h00, o_rx_soft_clear}, 8'h00);
      pulse_base = pulses;
      wrt(10'h081, 8'h01);
      repeat (4) @(posedge i_clk);
      chk(8'(pulses - pulse_base), 8'h01);
      wrt(10'h081, 8'h01);
      wrt(10'h081, 8'h00);
      wrt(10'h081, 8'h01);
      repeat (4) @(posedge i_clk);
      chk(8'(pulses - pulse_base), 8'h02);
      wrt(10'h080, 8'hc0);
      repeat (2) @(posedge i_clk);
      chk({7'h00, o_rx_standard_e1}, 8'h00);
      rdc(10'h081, 8'hfe);
      mf(8'h0f, 4'hc, 8'h77, 1'b0, 0);
      wrt(10'h080, 8'h00);
      wrt(10'h080, 8'h41);
      repeat (3) @(posedge i_clk);
      chk({7'h00, o_framer_run}, 8'h00);
      mf(8'hf0, 4'he, 8'h11, 1'b0, 2);
      test_done();
   end
endmodule
